/* rtl/ipa_gate.sv */
`timescale 1ns/10ps
`default_nettype none
// one source: level output and qualified request
module ipa_gate
    import ipa_pkg::*;
(
    // field and source state
    input  wire logic [2:0] field,
    input  wire logic       enable,
    input  wire logic       flag,
    // to arbitration
    output logic [2:0]      level,
    output logic            request
);
    // codes map one to one onto levels 0..7
    assign level   = field; // RL1 RL2
    // zero field silences the source whatever flag and enable say
    assign request = enable && flag && (field != LVL_OFF); // RL3 RL14
endmodule
`default_nettype wire

/* rtl/ipa_pkg.sv */
package ipa_pkg;
    // register byte addresses, one aligned word each
    localparam logic [5:0] ADDR_W = 6'd6;
    localparam logic [5:0] OFS_T2_OC2_IC2   = 6'h00;
    localparam logic [5:0] OFS_RX_SPI_T3    = 6'h04;
    localparam logic [5:0] OFS_ADC_TX       = 6'h08;
    localparam logic [5:0] OFS_CN_TWOWIRE   = 6'h0c;
    localparam logic [5:0] OFS_IC8_IC7_EXT1 = 6'h10;
    localparam logic [5:0] OFS_EXT2         = 6'h14;
    localparam logic [5:0] OFS_SER_ERR      = 6'h18;
    // qualified request outputs only, bit index = source number
    localparam logic [5:0] OFS_REQ_STATUS   = 6'h1c;
    // field positions (low bit of each 3-bit field)
    localparam int POS_HI  = 12;
    localparam int POS_MH  = 8;
    localparam int POS_ML  = 4;
    localparam int POS_LO  = 0;
    localparam int LVL_W   = 3;
    localparam int NSRC    = 17;
    // reset level: top bit set, lower two cleared
    localparam logic [2:0] LVL_RESET = 3'h4;
    localparam logic [2:0] LVL_OFF   = 3'h0;
    // implemented-bit masks per register
    localparam logic [15:0] MASK_T2_OC2_IC2   = 16'h7770;
    localparam logic [15:0] MASK_RX_SPI_T3    = 16'h7777;
    localparam logic [15:0] MASK_ADC_TX       = 16'h0077;
    localparam logic [15:0] MASK_CN_TWOWIRE   = 16'h7077;
    localparam logic [15:0] MASK_IC8_IC7_EXT1 = 16'h7707;
    localparam logic [15:0] MASK_EXT2         = 16'h0070;
    localparam logic [15:0] MASK_SER_ERR      = 16'h0070;
    localparam logic [15:0] RST_T2_OC2_IC2    = 16'h4440;
    localparam logic [15:0] RST_RX_SPI_T3     = 16'h4444;
    localparam logic [15:0] RST_ADC_TX        = 16'h0044;
    localparam logic [15:0] RST_CN_TWOWIRE    = 16'h4044;
    localparam logic [15:0] RST_IC8_IC7_EXT1  = 16'h4404;
    localparam logic [15:0] RST_EXT2          = 16'h0040;
    localparam logic [15:0] RST_SER_ERR       = 16'h0040;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {IPA_IDLE, IPA_RESP} ipa_state_t;
endpackage

/* rtl/ipa_top.sv */
// What this block does
// [RL1] field code 111 gives the source level 7, highest peripheral level
// [RL2] code 001 gives level 1; codes between map linearly to levels 2-6
// [RL3] code 000 disables the source entirely
// [RL4] unimplemented bits ignore writes and read zero
// [RL5] every field resets to 100, level 4
// [RL6] field bits are read/write and read back the last write
// [RL7] timer2, compare2, capture2 fields at 14-12, 10-8, 6-4
// [RL8] serial rx, spi event, spi error, timer3 at 14-12, 10-8, 6-4, 2-0
// [RL9] converter done at 6-4, serial tx at 2-0, upper bits unused
// [RL10] change notify 14-12, twowire master 6-4, twowire slave 2-0
// [RL11] capture8 14-12, capture7 10-8, external1 2-0
// [RL12] external2 field alone at bits 6-4
// [RL13] serial error field alone at bits 6-4
// [RL14] request needs enable, flag and nonzero field
// [RL15] peripheral levels never exceed 7; traps live above
// [RL16] levels driven continuously, writes effective next cycle
`timescale 1ns/10ps
`default_nettype none
module ipa_top
    import ipa_pkg::*;
(
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   rstn,
    // axi4-lite write address
    input  wire logic [ipa_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    // axi4-lite write response
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    // axi4-lite read address
    input  wire logic [ipa_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    // axi4-lite read data
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    // source enables and flags, bit index = source number
    input  wire logic [16:0]            src_enable,
    input  wire logic [16:0]            src_flag,
    // per-source levels to the arbitration
    output logic [2:0]                  timer2_level,
    output logic [2:0]                  compare2_level,
    output logic [2:0]                  capture2_level,
    output logic [2:0]                  serial_rx_level,
    output logic [2:0]                  spi_event_level,
    output logic [2:0]                  spi_error_level,
    output logic [2:0]                  timer3_level,
    output logic [2:0]                  converter_done_level,
    output logic [2:0]                  serial_tx_level,
    output logic [2:0]                  change_notify_level,
    output logic [2:0]                  twowire_master_level,
    output logic [2:0]                  twowire_slave_level,
    output logic [2:0]                  capture8_level,
    output logic [2:0]                  capture7_level,
    output logic [2:0]                  external1_level,
    output logic [2:0]                  external2_level,
    output logic [2:0]                  serial_error_level,
    // qualified requests, same bit order as the inputs
    output logic [16:0]                 src_request
);
    import ipa_pkg::*;

    logic [15:0] prio_timer2_compare2_capture2_reg;
    logic [15:0] prio_serial_rx_spi_timer3_reg;
    logic [15:0] prio_converter_serial_tx_reg;
    logic [15:0] prio_change_twowire_reg;
    logic [15:0] prio_capture8_capture7_ext1_reg;
    logic [15:0] prio_external2_reg;
    logic [15:0] prio_serial_error_reg;
    logic [ADDR_W-1:0] aw_addr_reg;
    logic        aw_held_reg;
    logic [31:0] w_data_reg;
    logic [3:0]  w_strb_reg;
    logic        w_held_reg;
    ipa_state_t  rd_state_reg;
    logic        do_write;
    logic [2:0]  lvl [NSRC];
    logic [NSRC*3-1:0] fields;

    // merge masked write into a register, only implemented bits change
    function automatic logic [15:0] wr_merge(input logic [15:0] old,
                                             input logic [15:0] mask,
                                             input logic [31:0] data,
                                             input logic [3:0]  strb);
        logic [15:0] be;
        be = {{8{strb[1]}}, {8{strb[0]}}};
        return (old & ~(be & mask)) | (data[15:0] & be & mask); // RL4 RL6
    endfunction

    // address hit on a word-aligned register
    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [ADDR_W-1:0] ofs);
        return a[ADDR_W-1:2] == ofs[ADDR_W-1:2];
    endfunction

    // write channels taken independently, either order
    assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
    assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
    assign do_write      = aw_held_reg && w_held_reg && !s_axi_bvalid;

    // capture address and data until both are present
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            aw_addr_reg <= '0;
            w_data_reg  <= 32'h0;
            w_strb_reg  <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            else if (do_write)
                aw_held_reg <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            else if (do_write)
                w_held_reg <= 1'b0;
        end
    end

    // write response, slverr for unmapped addresses
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end
        else if (do_write)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr_reg[ADDR_W-1:2] <= OFS_REQ_STATUS[ADDR_W-1:2])
                            ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // priority registers; reset every field to level 4
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            prio_timer2_compare2_capture2_reg <= RST_T2_OC2_IC2; // RL5
            prio_serial_rx_spi_timer3_reg     <= RST_RX_SPI_T3; // RL5
            prio_converter_serial_tx_reg      <= RST_ADC_TX; // RL5
            prio_change_twowire_reg           <= RST_CN_TWOWIRE; // RL5
            prio_capture8_capture7_ext1_reg   <= RST_IC8_IC7_EXT1; // RL5
            prio_external2_reg                <= RST_EXT2; // RL5
            prio_serial_error_reg             <= RST_SER_ERR; // RL5
        end
        else if (do_write)
        begin
            if (hit(aw_addr_reg, OFS_T2_OC2_IC2))
                prio_timer2_compare2_capture2_reg <= wr_merge(
                    prio_timer2_compare2_capture2_reg, MASK_T2_OC2_IC2,
                    w_data_reg, w_strb_reg); // RL7
            if (hit(aw_addr_reg, OFS_RX_SPI_T3))
                prio_serial_rx_spi_timer3_reg <= wr_merge(
                    prio_serial_rx_spi_timer3_reg, MASK_RX_SPI_T3,
                    w_data_reg, w_strb_reg); // RL8
            if (hit(aw_addr_reg, OFS_ADC_TX))
                prio_converter_serial_tx_reg <= wr_merge(
                    prio_converter_serial_tx_reg, MASK_ADC_TX,
                    w_data_reg, w_strb_reg); // RL9
            if (hit(aw_addr_reg, OFS_CN_TWOWIRE))
                prio_change_twowire_reg <= wr_merge(
                    prio_change_twowire_reg, MASK_CN_TWOWIRE,
                    w_data_reg, w_strb_reg); // RL10
            if (hit(aw_addr_reg, OFS_IC8_IC7_EXT1))
                prio_capture8_capture7_ext1_reg <= wr_merge(
                    prio_capture8_capture7_ext1_reg, MASK_IC8_IC7_EXT1,
                    w_data_reg, w_strb_reg); // RL11
            if (hit(aw_addr_reg, OFS_EXT2))
                prio_external2_reg <= wr_merge(prio_external2_reg, MASK_EXT2,
                    w_data_reg, w_strb_reg); // RL12
            if (hit(aw_addr_reg, OFS_SER_ERR))
                prio_serial_error_reg <= wr_merge(prio_serial_error_reg,
                    MASK_SER_ERR, w_data_reg, w_strb_reg); // RL13
        end
    end

    // read path: one read outstanding, answer one cycle after acceptance
    assign s_axi_arready = (rd_state_reg == IPA_IDLE);

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rd_state_reg <= IPA_IDLE;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= RESP_OKAY;
        end
        else
        begin
            case (rd_state_reg)
                IPA_IDLE:
                begin
                    if (s_axi_arvalid)
                    begin
                        rd_state_reg <= IPA_RESP;
                        s_axi_rvalid <= 1'b1;
                        s_axi_rresp  <= RESP_OKAY;
                        // upper half reads zero, except bit 16 of the request status
                        if (hit(s_axi_araddr, OFS_T2_OC2_IC2))
                            s_axi_rdata <= {16'h0, prio_timer2_compare2_capture2_reg};
                        else if (hit(s_axi_araddr, OFS_RX_SPI_T3))
                            s_axi_rdata <= {16'h0, prio_serial_rx_spi_timer3_reg};
                        else if (hit(s_axi_araddr, OFS_ADC_TX))
                            s_axi_rdata <= {16'h0, prio_converter_serial_tx_reg};
                        else if (hit(s_axi_araddr, OFS_CN_TWOWIRE))
                            s_axi_rdata <= {16'h0, prio_change_twowire_reg};
                        else if (hit(s_axi_araddr, OFS_IC8_IC7_EXT1))
                            s_axi_rdata <= {16'h0, prio_capture8_capture7_ext1_reg};
                        else if (hit(s_axi_araddr, OFS_EXT2))
                            s_axi_rdata <= {16'h0, prio_external2_reg};
                        else if (hit(s_axi_araddr, OFS_SER_ERR))
                            s_axi_rdata <= {16'h0, prio_serial_error_reg};
                        else if (hit(s_axi_araddr, OFS_REQ_STATUS))
                            s_axi_rdata <= {15'h0, src_request};
                        else
                        begin
                            s_axi_rdata <= 32'h0;
                            s_axi_rresp <= RESP_SLVERR;
                        end
                    end
                end
                IPA_RESP:
                begin
                    if (s_axi_rready)
                    begin
                        rd_state_reg <= IPA_IDLE;
                        s_axi_rvalid <= 1'b0;
                    end
                end
                default:
                    rd_state_reg <= IPA_IDLE;
            endcase
        end
    end

    // gather fields in source order (status bit index)
    assign fields = {
        prio_serial_error_reg[POS_ML +: LVL_W],
        prio_external2_reg[POS_ML +: LVL_W],
        prio_capture8_capture7_ext1_reg[POS_LO +: LVL_W],
        prio_capture8_capture7_ext1_reg[POS_MH +: LVL_W],
        prio_capture8_capture7_ext1_reg[POS_HI +: LVL_W],
        prio_change_twowire_reg[POS_LO +: LVL_W],
        prio_change_twowire_reg[POS_ML +: LVL_W],
        prio_change_twowire_reg[POS_HI +: LVL_W],
        prio_converter_serial_tx_reg[POS_LO +: LVL_W],
        prio_converter_serial_tx_reg[POS_ML +: LVL_W],
        prio_serial_rx_spi_timer3_reg[POS_LO +: LVL_W],
        prio_serial_rx_spi_timer3_reg[POS_ML +: LVL_W],
        prio_serial_rx_spi_timer3_reg[POS_MH +: LVL_W],
        prio_serial_rx_spi_timer3_reg[POS_HI +: LVL_W],
        prio_timer2_compare2_capture2_reg[POS_ML +: LVL_W],
        prio_timer2_compare2_capture2_reg[POS_MH +: LVL_W],
        prio_timer2_compare2_capture2_reg[POS_HI +: LVL_W]}; // RL16

    // one gate per source; 3-bit field caps peripherals at level 7
    for (genvar i = 0; i < NSRC; i++)
    begin : g_src
        ipa_gate u_gate (
            .field   (fields[i*3 +: 3]),
            .enable  (src_enable[i]),
            .flag    (src_flag[i]),
            .level   (lvl[i]),
            .request (src_request[i])
        ); // RL15
    end

    assign timer2_level         = lvl[0];
    assign compare2_level       = lvl[1];
    assign capture2_level       = lvl[2];
    assign serial_rx_level      = lvl[3];
    assign spi_event_level      = lvl[4];
    assign spi_error_level      = lvl[5];
    assign timer3_level         = lvl[6];
    assign converter_done_level = lvl[7];
    assign serial_tx_level      = lvl[8];
    assign change_notify_level  = lvl[9];
    assign twowire_master_level = lvl[10];
    assign twowire_slave_level  = lvl[11];
    assign capture8_level       = lvl[12];
    assign capture7_level       = lvl[13];
    assign external1_level      = lvl[14];
    assign external2_level      = lvl[15];
    assign serial_error_level   = lvl[16];

    // reset leaves every level at 4 until the first write
    AST_RESET_LEVEL: assert property (@(posedge clk) // RL5
        $rose(rstn) |-> timer2_level == LVL_RESET && serial_error_level == LVL_RESET)
        else $error("level not 4 after reset");
    // zero field means no request
    AST_ZERO_OFF: assert property (@(posedge clk) disable iff (!rstn) // RL3
        external2_level == LVL_OFF |-> !src_request[15])
        else $error("disabled source requests");
    // request iff enable, flag and nonzero level
    AST_REQ_QUAL: assert property (@(posedge clk) disable iff (!rstn) // RL14
        src_request[3] == (src_enable[3] && src_flag[3] && serial_rx_level != 3'h0))
        else $error("request qualification wrong");
    // write to timer3 field shows on level next cycle
    AST_WR_EFFECT: assert property (@(posedge clk) disable iff (!rstn) // RL16
        do_write && hit(aw_addr_reg, OFS_RX_SPI_T3) && w_strb_reg[0]
        |=> timer3_level == $past(w_data_reg[2:0]))
        else $error("timer3 write not applied");
    // unimplemented bits stay zero
    AST_UNIMP_ZERO: assert property (@(posedge clk) disable iff (!rstn) // RL4
        (prio_converter_serial_tx_reg & ~MASK_ADC_TX) == 16'h0
        && (prio_timer2_compare2_capture2_reg & ~MASK_T2_OC2_IC2) == 16'h0)
        else $error("unimplemented bit set");
    // compare2 field sits at bits 10-8
    AST_FIELD_POS: assert property (@(posedge clk) disable iff (!rstn) // RL7
        compare2_level == prio_timer2_compare2_capture2_reg[10:8])
        else $error("compare2 field misplaced");
    // read returns register contents one cycle after acceptance
    AST_READBACK: assert property (@(posedge clk) disable iff (!rstn) // RL6
        s_axi_arvalid && s_axi_arready && hit(s_axi_araddr, OFS_EXT2) && !do_write
        |=> s_axi_rvalid && s_axi_rdata[15:0] == prio_external2_reg)
        else $error("readback mismatch");
    // level 7 code passes straight through
    AST_TOP_LEVEL: assert property (@(posedge clk) disable iff (!rstn) // RL1
        prio_serial_error_reg[6:4] == 3'h7 |-> serial_error_level == 3'h7)
        else $error("code 111 not level 7");
endmodule
`default_nettype wire

/* verification/ipa_core_model.sv */
`timescale 1ns/10ps
`default_nettype none
// arbitration side: picks the highest level among requesting sources
module ipa_core_model
(
    // per-source levels, source i at bits 3i+2..3i
    input  wire logic [50:0] levels,
    input  wire logic [16:0] request,
    // winning level, zero when nothing requests
    output logic [2:0]       top_level
);
    // a 3-bit level caps peripherals at 7, so traps above can never be outranked
    always_comb
    begin
        top_level = 3'h0;
        for (int i = 0; i < 17; i++)
        begin
            // only a qualified request may compete
            if (request[i] && levels[3*i +: 3] > top_level)
                top_level = levels[3*i +: 3];
        end
    end
endmodule
`default_nettype wire

/* verification/ipa_top_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
    $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
module ipa_top_tb;
    import ipa_pkg::*;
    // bus and source stimulus
    logic        clk, rstn, awvalid, wvalid, bready, arvalid, rready;
    logic [5:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0]  wstrb;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, rsp;
    logic [16:0] en, flg, req;
    logic [2:0]  top, best;
    logic [15:0] shadow [7];
    wire  logic [50:0] lvv;
    int          n_mismatch, n_compared, cycles;
    // register table and per-source field placement
    localparam logic [5:0] ROFS [7] = '{OFS_T2_OC2_IC2, OFS_RX_SPI_T3, OFS_ADC_TX,
        OFS_CN_TWOWIRE, OFS_IC8_IC7_EXT1, OFS_EXT2, OFS_SER_ERR};
    localparam logic [15:0] RMSK [7] = '{16'h7770, 16'h7777, 16'h0077, 16'h7077,
        16'h7707, 16'h0070, 16'h0070};
    localparam logic [15:0] RRST [7] = '{16'h4440, 16'h4444, 16'h0044, 16'h4044,
        16'h4404, 16'h0040, 16'h0040};
    localparam int SREG [17] = '{0, 0, 0, 1, 1, 1, 1, 2, 2, 3, 3, 3, 4, 4, 4, 5, 6};
    localparam int SPOS [17] = '{12, 8, 4, 12, 8, 4, 0, 4, 0, 12, 4, 0, 12, 8, 0, 4, 4};

    ipa_top dut (.clk(clk), .rstn(rstn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .src_enable(en), .src_flag(flg),
        .timer2_level(lvv[2:0]), .compare2_level(lvv[5:3]), .capture2_level(lvv[8:6]),
        .serial_rx_level(lvv[11:9]), .spi_event_level(lvv[14:12]),
        .spi_error_level(lvv[17:15]), .timer3_level(lvv[20:18]),
        .converter_done_level(lvv[23:21]), .serial_tx_level(lvv[26:24]),
        .change_notify_level(lvv[29:27]), .twowire_master_level(lvv[32:30]),
        .twowire_slave_level(lvv[35:33]), .capture8_level(lvv[38:36]),
        .capture7_level(lvv[41:39]), .external1_level(lvv[44:42]),
        .external2_level(lvv[47:45]), .serial_error_level(lvv[50:48]),
        .src_request(req));
    ipa_core_model core (.levels(lvv), .request(req), .top_level(top));

    // clock, 100 ns period
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // hang guard: the whole sequence needs well under a thousand cycles
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_mismatch++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("compared %0d, mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // write: address and data offered together, each dropped once taken
    task automatic wr(input logic [5:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_go, w_go, b_go;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        b_go = 1'b0;
        while (!b_go)
        begin
            @(negedge clk);
            aw_go = awvalid && awready;
            w_go = wvalid && wready;
            b_go = bvalid && bready;
            r = bresp;
            @(posedge clk);
            if (aw_go) awvalid <= 1'b0;
            if (w_go) wvalid <= 1'b0;
        end
        bready <= 1'b0;
    endtask

    task automatic rdreg(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar_go, r_go;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        r_go = 1'b0;
        while (!r_go)
        begin
            @(negedge clk);
            ar_go = arvalid && arready;
            r_go = rvalid && rready;
            d = rdata;
            r = rresp;
            @(posedge clk);
            if (ar_go) arvalid <= 1'b0;
        end
        rready <= 1'b0;
    endtask

    initial
    begin
        {rstn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, cycles, n_mismatch, n_compared} = '0;
        wstrb = 4'hf;
        en = '1;
        flg = '1;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        // reset values and reserved bits, then all-ones write back
        for (int k = 0; k < 7; k++)
        begin
            rdreg(ROFS[k], rd, rsp);
            `CHK(rd, {16'h0, RRST[k]})
            wr(ROFS[k], 32'hffff_ffff, rsp);
            `CHK(rsp, RESP_OKAY)
            rdreg(ROFS[k], rd, rsp);
            `CHK({rsp, rd}, {RESP_OKAY, 16'h0, RMSK[k]})
        end
        @(negedge clk);
        `CHK(lvv, {17{3'h7}})
        `CHK(top, 3'h7)
        // every field zero: no source may request
        for (int k = 0; k < 7; k++)
            wr(ROFS[k], 32'h0, rsp);
        @(negedge clk);
        `CHK(req, 17'h0)
        `CHK(top, 3'h0)
        // each field lands on its own source, built up one at a time
        shadow = '{default: 16'h0};
        best = 3'h0;
        for (int i = 0; i < 17; i++)
        begin
            shadow[SREG[i]] = shadow[SREG[i]] | (16'(i % 7 + 1) << SPOS[i]);
            best = (3'(i % 7 + 1) > best) ? 3'(i % 7 + 1) : best;
            wr(ROFS[SREG[i]], {16'h0, shadow[SREG[i]]}, rsp);
            @(negedge clk);
            `CHK(lvv[3*i +: 3], 3'(i % 7 + 1))
            `CHK(top, best)
        end
        // every code of one field, request follows a nonzero level
        for (int c = 0; c < 8; c++)
        begin
            wr(OFS_T2_OC2_IC2, 32'(c) << 12, rsp);
            @(negedge clk);
            `CHK(lvv[2:0], 3'(c))
            `CHK(req[0], (c != 0))
        end
        // low byte strobe only: the upper two fields keep 4 and 5
        @(posedge clk);
        wstrb <= 4'h1;
        wr(OFS_RX_SPI_T3, 32'hffff_ffff, rsp);
        wstrb <= 4'hf;
        rdreg(OFS_RX_SPI_T3, rd, rsp);
        `CHK(rd, 32'h0000_4577)
        // enable or flag missing blocks the request
        @(posedge clk);
        en[0] <= 1'b0;
        @(negedge clk);
        `CHK(req[0], 1'b0)
        @(posedge clk);
        en[0] <= 1'b1;
        flg[0] <= 1'b0;
        // source 0 lacks its flag, sources 1 and 2 sit at level 0
        rdreg(OFS_REQ_STATUS, rd, rsp);
        `CHK(rd, 32'h0001_fff8)
        // unmapped place answers with an error and reads zero
        rdreg(6'h20, rd, rsp);
        `CHK({rsp, rd}, {RESP_SLVERR, 32'h0})
        wr(6'h20, 32'hffff_ffff, rsp);
        `CHK(rsp, RESP_SLVERR)
        // reset in mid-run restores level 4 everywhere
        @(posedge clk);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        `CHK(lvv, {17{3'h4}})
        `CHK(req, 17'h1_fffe)
        // release on a rising edge, then the first read right away
        @(posedge clk);
        rstn <= 1'b1;
        rdreg(OFS_SER_ERR, rd, rsp);
        `CHK(rd, {16'h0, RRST[6]})
        complete_run();
    end
endmodule
`default_nettype wire
